/* logic/fwu_defs.svh */
// register offsets, field positions, reset values and timing for the unlock sequencer
// assumes a 125 MHz system clock and byte offsets on a 32-bit avalon slave
`ifndef FWU_DEFS_SVH
`define FWU_DEFS_SVH
`define FWU_OFF_FCR 6'h00
`define FWU_OFF_STAT 6'h04
`define FWU_OFF_DATA 6'h20
`define FWU_FCR_CLR_BIT 7
`define FWU_FCR_MODE_LSB 4
`define FWU_FCR_TRIG_BIT 3
`define FWU_FCR_WR_BIT 2
`define FWU_FCR_RDEN_BIT 1
`define FWU_FCR_RD_BIT 0
`define FWU_STAT_PERMIT_BIT 0
`define FWU_STAT_ACTIVE_BIT 1
`define FWU_STAT_FAIL_BIT 2
`define FWU_STAT_TIMEOUT_BIT 3
`define FWU_FCR_RST 8'h00
`define FWU_MODE_WRITE 3'h0
`define FWU_MODE_ERASE 3'h1
`define FWU_MODE_READ 3'h3
`define FWU_MODE_PERMIT 3'h6
`define FWU_KEY 48'h00040d09c340
`define FWU_KEY_LEN 6
`define FWU_KEY_FIRST_SLOT 3'h2
`define FWU_WINDOW_US 1000
`define FWU_CLK_MHZ 125
`define FWU_WINDOW_CYCLES (`FWU_WINDOW_US * `FWU_CLK_MHZ)
`endif

/* logic/fwu_pkg.sv */
// types shared by the unlock sequencer files
// assumes the constants of fwu_defs.svh
package fwu_pkg;
   typedef enum logic [2:0] {MODE_WRITE, MODE_ERASE, MODE_READ, MODE_PERMIT, MODE_RSVD} fwu_mode_type;
   typedef enum logic {ULK_IDLE, ULK_WINDOW} fwu_ulk_state_type;
   typedef enum logic [1:0] {BUS_IDLE, BUS_FETCH, BUS_ANSWER} fwu_bus_state_type;
endpackage

/* logic/fwu_mem_if.sv */
// carrier between the sequencer and its flash data register store
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface fwu_mem_if #(parameter int AW = 3, parameter int DW = 8);
   logic we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;
   modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* logic/fwu_data_mem.sv */
// flash data register store, one byte per register, registered read
// assumes the caller tolerates one cycle of read latency
`timescale 1ns/1ps
module fwu_data_mem #(
   parameter int DEPTH = 8
)(
   input wire logic clk_i,
   input wire logic rstn_i,
   fwu_mem_if.mem port
);
   logic [$bits(port.wdata)-1:0] store_reg [DEPTH];
   logic [$bits(port.wdata)-1:0] rdata_reg;

   // no reset on the array: contents are don't-care until written
   always_ff @(posedge clk_i) begin
      if (port.we) begin
         store_reg[port.waddr] <= port.wdata;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= store_reg[port.raddr];
      end
   end

   assign port.rdata = rdata_reg;
endmodule

/* logic/fwu_top.sv */
// flash write-permit unlock sequencer with avalon-mm register slave
// assumes a 125 MHz clock and a master that honours waitrequest
//
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "fwu_defs.svh"
// Overview of operation
// RQ1 - software selects mode 110 first
// RQ2 - software then writes trigger bit one
// RQ3 - trigger in permit mode opens 1ms window
// RQ4 - software writes key into data registers one-three
// RQ5 - key 00 04 0d 09 c3 40 required
// RQ6 - timeout or wrong byte abandons, permit stays off
// RQ7 - trigger bit self-clears when attempt ends
// RQ8 - flash cycles honoured only with permit; read cycles need only the read enable
// RQ9 - clearing permit-clear bit revokes permit immediately
// RQ10 - clear bit writes clear, reads permit
// RQ11 - mode codes 000 001 011 110, rest reserved
// RQ12 - key order one low, high, two, three
// RQ13 - permit reset low, held until cleared
module fwu_top #(
   parameter int WINDOW_CYCLES = `FWU_WINDOW_CYCLES,
   parameter int DATA_DEPTH = 8
)(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic flash_write_permit_o,
   output logic flash_write_cycle_o,
   output logic flash_erase_cycle_o,
   output logic flash_read_cycle_o
);
   localparam int CNT_W = $clog2(WINDOW_CYCLES + 1);

   // RQ11 code decode
   function automatic fwu_pkg::fwu_mode_type fwu_mode_decode(input logic [2:0] code);
      if (code == `FWU_MODE_WRITE) return fwu_pkg::MODE_WRITE;
      else if (code == `FWU_MODE_ERASE) return fwu_pkg::MODE_ERASE;
      else if (code == `FWU_MODE_READ) return fwu_pkg::MODE_READ;
      else if (code == `FWU_MODE_PERMIT) return fwu_pkg::MODE_PERMIT;
      else return fwu_pkg::MODE_RSVD;
   endfunction

   function automatic logic [7:0] fwu_key_byte(input logic [2:0] idx);
      logic [47:0] key;
      key = `FWU_KEY;
      return key[47 - 8 * int'(idx) -: 8];
   endfunction

   fwu_mem_if #(.AW(3), .DW(8)) mem_port ();
   fwu_data_mem #(.DEPTH(DATA_DEPTH)) u_mem (.clk_i(clk_i), .rstn_i(rstn_i), .port(mem_port));

   fwu_pkg::fwu_bus_state_type bus_reg, bus_next;
   fwu_pkg::fwu_ulk_state_type ulk_reg, ulk_next;
   logic wait_reg;
   logic [31:0] rdata_reg, rdata_next;
   logic [2:0] mode_reg;
   logic trig_reg, trig_next;
   logic rden_reg;
   logic permit_reg, permit_next;
   logic fail_reg, timeout_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [2:0] idx_reg;
   logic wcyc_reg, ecyc_reg, rcyc_reg;

   // bus decode
   wire req_w = avs_read_i | avs_write_i;
   wire wr_w = avs_write_i & ~wait_reg & avs_byteenable_i[0];
   wire sel_fcr_w = avs_address_i == `FWU_OFF_FCR;
   wire sel_stat_w = avs_address_i == `FWU_OFF_STAT;
   wire sel_data_w = avs_address_i[5] & (avs_address_i[1:0] == 2'b00);
   wire fcr_wr_w = wr_w & sel_fcr_w;
   wire [7:0] wd_w = avs_writedata_i[7:0];
   wire [2:0] wslot_w = avs_address_i[4:2];
   wire fwu_pkg::fwu_mode_type wmode_w = fwu_mode_decode(wd_w[`FWU_FCR_MODE_LSB +: 3]);
   wire in_win_w = ulk_reg == fwu_pkg::ULK_WINDOW;

   // RQ3 window opens
   wire start_w = fcr_wr_w & wd_w[`FWU_FCR_TRIG_BIT] & (wmode_w == fwu_pkg::MODE_PERMIT) & ~in_win_w;
   // RQ12 slot order, fd0 not part of key
   wire key_wr_w = in_win_w & mem_port.we & (wslot_w >= `FWU_KEY_FIRST_SLOT);
   wire slot_ok_w = wslot_w == (`FWU_KEY_FIRST_SLOT + idx_reg);
   // RQ5 byte compare
   wire byte_ok_w = wd_w == fwu_key_byte(idx_reg);
   wire mismatch_w = key_wr_w & ~(slot_ok_w & byte_ok_w);
   wire done_w = key_wr_w & slot_ok_w & byte_ok_w & (idx_reg == 3'(`FWU_KEY_LEN - 1));
   wire timeout_w = in_win_w & (cnt_reg == CNT_W'(WINDOW_CYCLES - 1));
   // completing key on the last window cycle still counts
   wire end_w = in_win_w & (timeout_w | mismatch_w | done_w);
   wire fail_w = end_w & ~done_w;

   assign mem_port.we = wr_w & sel_data_w;
   assign mem_port.waddr = wslot_w;
   assign mem_port.wdata = wd_w;
   assign mem_port.raddr = wslot_w;

   always_comb begin
      bus_next = bus_reg;
      case (bus_reg)
         fwu_pkg::BUS_IDLE: begin
            if (req_w) bus_next = fwu_pkg::BUS_FETCH;
         end
         fwu_pkg::BUS_FETCH: begin
            bus_next = fwu_pkg::BUS_ANSWER;
         end
         default: begin
            bus_next = fwu_pkg::BUS_IDLE;
         end
      endcase
   end

   // RQ10 clear bit reads back the permit
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (sel_fcr_w) begin
         rdata_next[7:0] = {permit_reg, mode_reg, trig_reg, 1'b0, rden_reg, 1'b0};
      end else if (sel_stat_w) begin
         rdata_next[3:0] = {timeout_reg, fail_reg, in_win_w, permit_reg};
      end else if (sel_data_w) begin
         rdata_next[7:0] = mem_port.rdata;
      end
   end

   // RQ7 trigger stands while the attempt runs; a trigger write in any other mode stands one cycle
   assign trig_next = (fcr_wr_w & wd_w[`FWU_FCR_TRIG_BIT] & ~in_win_w) | (in_win_w & ~end_w);
   // RQ9 revoke; RQ13 set wins over a clear in the same cycle
   assign permit_next = done_w ? 1'b1 : (fcr_wr_w & ~wd_w[`FWU_FCR_CLR_BIT]) ? 1'b0 : permit_reg;
   assign ulk_next = start_w ? fwu_pkg::ULK_WINDOW : end_w ? fwu_pkg::ULK_IDLE : ulk_reg;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bus_reg <= fwu_pkg::BUS_IDLE;
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end else begin
         bus_reg <= bus_next;
         wait_reg <= bus_next != fwu_pkg::BUS_ANSWER;
         if (bus_reg == fwu_pkg::BUS_FETCH) rdata_reg <= rdata_next;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_reg <= 3'(`FWU_FCR_RST >> `FWU_FCR_MODE_LSB);
         rden_reg <= 1'b0;
         trig_reg <= 1'b0;
         permit_reg <= 1'b0;
         ulk_reg <= fwu_pkg::ULK_IDLE;
      end else begin
         if (fcr_wr_w) mode_reg <= wd_w[`FWU_FCR_MODE_LSB +: 3];
         if (fcr_wr_w) rden_reg <= wd_w[`FWU_FCR_RDEN_BIT];
         trig_reg <= trig_next;
         permit_reg <= permit_next;
         ulk_reg <= ulk_next;
      end
   end

   // RQ6 window count and outcome flags
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_reg <= '0;
         idx_reg <= 3'h0;
         fail_reg <= 1'b0;
         timeout_reg <= 1'b0;
      end else begin
         cnt_reg <= in_win_w ? cnt_reg + 1'b1 : '0;
         idx_reg <= !in_win_w ? 3'h0 : (key_wr_w ? idx_reg + 3'h1 : idx_reg);
         if (start_w) fail_reg <= 1'b0;
         else if (fail_w) fail_reg <= 1'b1;
         if (start_w) timeout_reg <= 1'b0;
         else if (fail_w & timeout_w & ~mismatch_w) timeout_reg <= 1'b1;
      end
   end

   // RQ8 cycles need the permit; read needs its enable
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wcyc_reg <= 1'b0;
         ecyc_reg <= 1'b0;
         rcyc_reg <= 1'b0;
      end else begin
         wcyc_reg <= fcr_wr_w & wd_w[`FWU_FCR_WR_BIT] & permit_reg & (wmode_w == fwu_pkg::MODE_WRITE);
         ecyc_reg <= fcr_wr_w & wd_w[`FWU_FCR_WR_BIT] & permit_reg & (wmode_w == fwu_pkg::MODE_ERASE);
         rcyc_reg <= fcr_wr_w & wd_w[`FWU_FCR_RD_BIT] & rden_reg & (wmode_w == fwu_pkg::MODE_READ);
      end
   end

   assign avs_readdata_o = rdata_reg;
   assign avs_waitrequest_o = wait_reg;
   assign flash_write_permit_o = permit_reg;
   assign flash_write_cycle_o = wcyc_reg;
   assign flash_erase_cycle_o = ecyc_reg;
   assign flash_read_cycle_o = rcyc_reg;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   property p_window_start;
      start_w |=> in_win_w && trig_reg && cnt_reg == 1'b0;
   endproperty
   a_window_start: assert property (p_window_start) else $error("window did not open"); // RQ3
   property p_key_cause;
      $rose(permit_reg) |-> $past(done_w) && $past(wd_w) == 8'h40;
   endproperty
   a_key_cause: assert property (p_key_cause) else $error("permit set without full key"); // RQ5
   property p_fail_stays_off;
      fail_w && !permit_reg |=> !permit_reg && !in_win_w;
   endproperty
   a_fail_stays_off: assert property (p_fail_stays_off) else $error("failed attempt granted permit"); // RQ6
   property p_timeout;
      in_win_w && cnt_reg == CNT_W'(WINDOW_CYCLES - 1) && !done_w |=> !in_win_w && fail_reg;
   endproperty
   a_timeout: assert property (p_timeout) else $error("window overran"); // RQ6
   property p_trig_clear;
      end_w |=> !trig_reg ##1 (!trig_reg || $past(fcr_wr_w && wd_w[`FWU_FCR_TRIG_BIT]));
   endproperty
   a_trig_clear: assert property (p_trig_clear) else $error("trigger not cleared"); // RQ7
   property p_cycle_gate;
      flash_write_cycle_o || flash_erase_cycle_o |-> $past(permit_reg);
   endproperty
   a_cycle_gate: assert property (p_cycle_gate) else $error("flash cycle without permit"); // RQ8
   property p_revoke;
      fcr_wr_w && !wd_w[`FWU_FCR_CLR_BIT] && !done_w |=> !flash_write_permit_o;
   endproperty
   a_revoke: assert property (p_revoke) else $error("permit not revoked"); // RQ9
   property p_reserved;
      fcr_wr_w && wd_w[`FWU_FCR_TRIG_BIT] && wmode_w == fwu_pkg::MODE_RSVD && !in_win_w |=> !in_win_w ##1 !trig_reg;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved mode opened window"); // RQ11
   property p_order;
      key_wr_w && !slot_ok_w |=> !in_win_w && fail_reg;
   endproperty
   a_order: assert property (p_order) else $error("out of order key accepted"); // RQ12
   property p_hold;
      permit_reg && !(fcr_wr_w && !wd_w[`FWU_FCR_CLR_BIT]) |=> permit_reg;
   endproperty
   a_hold: assert property (p_hold) else $error("permit dropped by itself"); // RQ13
   c_unlock: cover property (done_w ##1 permit_reg);
   c_timeout: cover property (timeout_w && !done_w);
   c_mismatch: cover property (mismatch_w);
   c_write_cycle: cover property (flash_write_cycle_o);
endmodule

/* testbench/tb.sv */
// self-checking bench for the flash write-permit unlock sequencer
// assumes fwu_top with a shortened window and avalon-mm register access
`timescale 1ns/1ps
module tb;
   localparam int WIN = 64;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [5:0] avs_address_i = 6'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hf;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic flash_write_permit_o;
   logic flash_write_cycle_o;
   logic flash_erase_cycle_o;
   logic flash_read_cycle_o;
   logic [3:0] be_v = 4'hf;
   logic [31:0] q;
   logic [7:0] key_b [6] = '{8'h00, 8'h04, 8'h0d, 8'h09, 8'hc3, 8'h40};
   int error_cnt = 0;
   int n_checks = 0;
   int n_wr = 0;
   int n_er = 0;
   int n_rd = 0;

   fwu_top #(.WINDOW_CYCLES(WIN), .DATA_DEPTH(8)) fwu_top_inst (
      .clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .flash_write_permit_o(flash_write_permit_o), .flash_write_cycle_o(flash_write_cycle_o),
      .flash_erase_cycle_o(flash_erase_cycle_o), .flash_read_cycle_o(flash_read_cycle_o));

   always #4 clk_i = ~clk_i;

   // pulses are one cycle wide, so count them rather than poll; mid-cycle avoids an edge race
   always @(negedge clk_i) begin
      if (flash_write_cycle_o === 1'b1) n_wr++;
      if (flash_erase_cycle_o === 1'b1) n_er++;
      if (flash_read_cycle_o === 1'b1) n_rd++;
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one idle edge after release keeps a back-to-back call from driving twice in a step
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_byteenable_i <= be_v;
      avs_write_i <= w;
      avs_read_i <= ~w;
      do begin
         @(posedge clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 100);
      if (n >= 100) chk("waitrequest", 1'b1, 1'b0);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      bus(1'b1, a, {24'h0, d});
   endtask

   task automatic rd(input logic [5:0] a);
      bus(1'b0, a, 32'h0);
   endtask

   task automatic send_key(input int n);
      for (int i = 0; i < n; i++) wr(6'(6'h28 + 6'(4 * i)), key_b[i]);
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      final_report();
   end

   initial begin
      repeat (3) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      chk("permit rst", flash_write_permit_o, 1'b0);
      rd(6'h00);
      chk("ctl rst", q, 32'h0);
      rd(6'h04);
      chk("stat rst", q, 32'h0);
      $display("test reset done");
      wr(6'h00, 8'h84);
      wr(6'h00, 8'h94);
      chk("wr no permit", n_wr, 0);
      chk("er no permit", n_er, 0);
      chk("set bit no effect", flash_write_permit_o, 1'b0);
      wr(6'h00, 8'h32);
      wr(6'h00, 8'h33);
      wr(6'h00, 8'h03);
      chk("read mode only", n_rd, 1);
      wr(6'h00, 8'h38);
      rd(6'h04);
      chk("no window other mode", q & 32'h2, 32'h0);
      wr(6'h00, 8'ha8);
      rd(6'h04);
      chk("no window reserved", q & 32'h2, 32'h0);
      rd(6'h00);
      chk("trig cleared", q & 32'h8, 32'h0);
      $display("test modes done");
      wr(6'h00, 8'he8);
      rd(6'h00);
      chk("trig held", q & 32'h8, 32'h8);
      rd(6'h04);
      chk("window open", q & 32'h2, 32'h2);
      send_key(6);
      chk("permit set", flash_write_permit_o, 1'b1);
      rd(6'h00);
      chk("ctl after ok", q, 32'he0);
      rd(6'h3c);
      chk("data hi3", q, 32'h40);
      rd(6'h04);
      chk("stat ok", q & 32'h3, 32'h1);
      $display("test unlock done");
      wr(6'h00, 8'h84);
      wr(6'h00, 8'h94);
      chk("wr permitted", n_wr, 1);
      chk("er permitted", n_er, 1);
      chk("set bit keeps permit", flash_write_permit_o, 1'b1);
      be_v = 4'he;
      wr(6'h00, 8'h00);
      be_v = 4'hf;
      chk("lane off ignored", flash_write_permit_o, 1'b1);
      rd(6'h10);
      chk("unmapped", q, 32'h0);
      wr(6'h00, 8'h00);
      chk("permit revoked", flash_write_permit_o, 1'b0);
      rd(6'h00);
      chk("clear reads permit", q & 32'h80, 32'h0);
      $display("test permit done");
      wr(6'h00, 8'he8);
      send_key(2);
      wr(6'h30, 8'h0e);
      rd(6'h04);
      chk("bad byte stat", q & 32'h6, 32'h4);
      rd(6'h00);
      chk("trig after fail", q & 32'h8, 32'h0);
      for (int i = 3; i < 6; i++) wr(6'(6'h28 + 6'(4 * i)), key_b[i]);
      chk("no permit bad byte", flash_write_permit_o, 1'b0);
      wr(6'h00, 8'he8);
      wr(6'h2c, key_b[0]);
      send_key(6);
      chk("no permit bad slot", flash_write_permit_o, 1'b0);
      $display("test bad key done");
      wr(6'h00, 8'he8);
      send_key(5);
      // the window is counted from the trigger edge
      repeat (WIN) @(posedge clk_i);
      rd(6'h04);
      chk("timeout stat", q & 32'he, 32'hc);
      rd(6'h00);
      chk("trig after timeout", q & 32'h8, 32'h0);
      wr(6'h3c, key_b[5]);
      chk("no permit late", flash_write_permit_o, 1'b0);
      $display("test timeout done");
      final_report();
   end
endmodule
